// file: core/por_ctrl.sv
// Power-on clear sequencing, chip-enable restart and carry-seen flag logic.
// Assumes comparator outputs for both supply thresholds and the CE pin arrive
// asynchronously; register port and core strobes are on mclk_i.
//
// Overview of operation
// - Clock stopped: clear below low threshold
// - Clock-stop recovery needs normal threshold, 50 ms
// - Ramp from zero: clear, then 50 ms halt
// - Supply and CE together: one start
// - CE during forced halt: single start only
// - CE after start: restart at next carry
// - Never above normal threshold: stay cleared
// - CE wake: normal threshold after 50 ms
// - Clear sets disable; flag read resets it
// - Disable blocks carry-seen flag setting
// - Power-on start has flag cleared
// - After read, every carry rise sets flag
// - Reading the flag clears it
// - Flag zero: power-on; one: chip-enable
// - Failure threshold equals clear threshold
// - Reset sets carry period 100 ms
// - Clear stops oscillator, holds core reset
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
module por_ctrl #(
    parameter int unsigned TICK_CYC = por_pkg::TICK_CYC
) (
    input  wire logic                       mclk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       vdd_hi_ok_i,
    input  wire logic                       vdd_lo_ok_i,
    input  wire logic                       ce_pin_i,
    input  wire logic                       clock_stop_i,
    input  wire logic [por_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [por_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [por_pkg::DATA_W-1:0] rdata_o,
    output logic                            supply_low_clear_o,
    output logic                            osc_en_o,
    output logic                            core_reset_o,
    output logic                            core_halt_o,
    output logic                            start_o,
    output logic                            start_poc_o,
    output logic                            carry_pulse_o
);
    typedef enum logic [1:0] {
        ST_CLEAR    = 2'b00,
        ST_POC_HALT = 2'b01,
        ST_RUN      = 2'b10,
        ST_CE_WAIT  = 2'b11
    } por_state_t;

    por_state_t                  state;
    por_state_t                  next_state;
    logic [2:0]                  pin_raw;
    logic [2:0]                  s1;
    logic [2:0]                  s2;
    logic [2:0]                  s3;
    logic [2:0]                  pin_q;
    logic                        ce_d;
    logic                        ce_rise;
    logic                        low_th;
    logic                        wake_act;
    logic [7:0]                  wake_cnt;
    logic [por_pkg::TICK_W-1:0]  tick_cnt;
    logic                        tick;
    logic [7:0]                  half_cnt;
    logic [7:0]                  period;
    logic                        carry_sig;
    logic                        carry_rise;
    logic [1:0]                  ctrl_sel;
    logic                        dis_ff;
    logic                        flag;
    logic                        stat_rd;
    logic                        clr;

    assign pin_raw = {ce_pin_i, vdd_lo_ok_i, vdd_hi_ok_i};

    // Three-stage sync; a change counts once stages two and three agree
    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
                s1[i]    <= 1'b0;
                s2[i]    <= 1'b0;
                s3[i]    <= 1'b0;
                pin_q[i] <= 1'b0;
            end else begin
                s1[i] <= pin_raw[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    pin_q[i] <= s3[i];
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ce_d <= 1'b0;
        end else begin
            ce_d <= pin_q[por_pkg::PIN_CE];
        end
    end
    assign ce_rise = pin_q[por_pkg::PIN_CE] & ~ce_d;

    assign clr = low_th ? ~pin_q[por_pkg::PIN_LO] : ~pin_q[por_pkg::PIN_HI];
    assign supply_low_clear_o = clr;

    // low threshold until 50 ms after CE wake
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            low_th   <= 1'b0;
            wake_act <= 1'b0;
            wake_cnt <= 8'h00;
        end else if (clr) begin
            // Recovery always demands the normal threshold
            low_th   <= 1'b0;
            wake_act <= 1'b0;
            wake_cnt <= 8'h00;
        end else if (wake_act) begin
            if (tick) begin
                wake_cnt <= wake_cnt + 8'h01;
                if (wake_cnt == por_pkg::WAKE_TICKS - 8'h01) begin
                    low_th   <= 1'b0;
                    wake_act <= 1'b0;
                end
            end
        end else if (low_th && ce_rise) begin
            wake_act <= 1'b1;
            wake_cnt <= 8'h00;
        end else if (clock_stop_i && state == ST_RUN) begin
            low_th <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || clr) begin
            tick_cnt <= '0;
        end else if (tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + por_pkg::TICK_W'(1);
        end
    end
    assign tick = (tick_cnt == por_pkg::TICK_W'(TICK_CYC - 1));

    always_comb begin
        case (ctrl_sel)
            por_pkg::SEL_100MS: period = por_pkg::PER_100MS;
            por_pkg::SEL_1MS:   period = por_pkg::PER_1MS;
            por_pkg::SEL_5MS:   period = por_pkg::PER_5MS;
            por_pkg::SEL_10MS:  period = por_pkg::PER_10MS;
            default:            period = por_pkg::PER_100MS;
        endcase
    end

    // Half period in 0.5 ms ticks, so first rise is half a period after clear
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || clr) begin
            half_cnt  <= 8'h00;
            carry_sig <= 1'b0;
        end else if (tick) begin
            if (half_cnt >= period - 8'h01) begin
                half_cnt  <= 8'h00;
                carry_sig <= ~carry_sig;
            end else begin
                half_cnt <= half_cnt + 8'h01;
            end
        end
    end
    assign carry_rise    = tick && (half_cnt >= period - 8'h01) && !carry_sig && !clr;
    assign carry_pulse_o = carry_sig;

    // period back to 100 ms on reset and clear
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || clr) begin
            ctrl_sel <= por_pkg::SEL_100MS;
        end else if (wr_i && addr_i == por_pkg::REG_CTRL) begin
            ctrl_sel <= {wdata_i[por_pkg::SEL_HI_BIT], wdata_i[por_pkg::SEL_LO_BIT]};
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_CLEAR:    next_state = ST_POC_HALT;
            ST_POC_HALT: if (carry_rise) next_state = ST_RUN;
            ST_RUN:      if (ce_rise) next_state = ST_CE_WAIT;
            ST_CE_WAIT:  if (carry_rise) next_state = ST_RUN;
            default:     next_state = ST_CLEAR;
        endcase
        if (clr) begin
            next_state = ST_CLEAR;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state <= ST_CLEAR;
        end else begin
            state <= next_state;
        end
    end

    // start from address zero on carry rise
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            start_o     <= 1'b0;
            start_poc_o <= 1'b0;
        end else begin
            start_o <= !clr && carry_rise && (state == ST_POC_HALT || state == ST_CE_WAIT);
            if (!clr && carry_rise && state == ST_POC_HALT) begin
                start_poc_o <= 1'b1;
            end else if (!clr && carry_rise && state == ST_CE_WAIT) begin
                start_poc_o <= 1'b0;
            end
        end
    end

    assign core_reset_o = (state == ST_CLEAR);
    assign core_halt_o  = (state != ST_RUN);
    assign osc_en_o     = ~clr;

    assign stat_rd = rd_i && addr_i == por_pkg::REG_STAT;

    // disable set by clear, reset by read
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || clr) begin
            dis_ff <= 1'b1;
        end else if (stat_rd) begin
            dis_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || clr) begin
            flag <= 1'b0;
        end else if (carry_rise && !dis_ff) begin
            flag <= 1'b1;
        end else if (stat_rd) begin
            flag <= 1'b0;
        end
    end

    // flag read shows the reset cause
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= '0;
            if (rd_i && addr_i == por_pkg::REG_CTRL) begin
                rdata_o[por_pkg::SEL_HI_BIT] <= ctrl_sel[1];
                rdata_o[por_pkg::SEL_LO_BIT] <= ctrl_sel[0];
            end else if (stat_rd) begin
                rdata_o[por_pkg::FLAG_BIT]  <= flag;
                rdata_o[por_pkg::DIS_BIT]   <= dis_ff;
                rdata_o[por_pkg::CLR_BIT]   <= clr;
                rdata_o[por_pkg::POC_BIT]   <= start_poc_o;
                rdata_o[por_pkg::LOWTH_BIT] <= low_th;
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_clr_halts;
        clr |=> core_reset_o && core_halt_o;
    endproperty
    a_clr_halts: assert property (p_clr_halts) else $error("clear did not halt core");

    property p_poc_start;
        state == ST_POC_HALT && carry_rise |=> start_o && start_poc_o ##1 !start_o;
    endproperty
    a_poc_start: assert property (p_poc_start) else $error("power-on start missing");

    property p_ce_ignored;
        state == ST_POC_HALT && ce_rise && !carry_rise && !clr |=> state == ST_POC_HALT && !start_o;
    endproperty
    a_ce_ignored: assert property (p_ce_ignored) else $error("CE acted during forced halt");

    property p_ce_restart;
        state == ST_RUN && ce_rise && !clr |=> state == ST_CE_WAIT && core_halt_o;
    endproperty
    a_ce_restart: assert property (p_ce_restart) else $error("CE rise not taken");

    property p_dis_set;
        clr |=> dis_ff && !flag;
    endproperty
    a_dis_set: assert property (p_dis_set) else $error("disable not set by clear");

    property p_no_set;
        dis_ff && !flag |=> !flag;
    endproperty
    a_no_set: assert property (p_no_set) else $error("flag set while disabled");

    property p_start_zero;
        start_o && start_poc_o |-> !flag;
    endproperty
    a_start_zero: assert property (p_start_zero) else $error("flag set at power-on start");

    property p_flag_set;
        !dis_ff && carry_rise |=> flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("carry rise did not set flag");

    property p_rd_clr;
        stat_rd && !carry_rise && !clr ##1 !rd_i |-> !flag && !dis_ff ##1 rdata_o == '0;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("read did not clear flag");

    property p_per_rst;
        core_reset_o |-> period == por_pkg::PER_100MS;
    endproperty
    a_per_rst: assert property (p_per_rst) else $error("period not 100 ms in clear");

    c_poc_start: cover property (state == ST_POC_HALT ##1 start_o && start_poc_o);
    c_ce_start: cover property (state == ST_CE_WAIT ##1 start_o && !start_poc_o);
    c_wake: cover property (wake_act && tick && wake_cnt == por_pkg::WAKE_TICKS - 8'h01);
    c_flag_rd: cover property (flag && stat_rd);
endmodule : por_ctrl

// file: core/por_pkg.sv
// Constants for the power-on clear and power-failure flag block.
// Assumes a 250 MHz core clock and a 0.5 ms time base derived from it.
package por_pkg;
    localparam int unsigned      ADDR_W       = 4;
    localparam int unsigned      DATA_W       = 8;
    localparam logic [3:0]       REG_CTRL     = 4'h0;
    localparam logic [3:0]       REG_STAT     = 4'h1;
    // Control register fields
    localparam int unsigned      SEL_LO_BIT   = 0;
    localparam int unsigned      SEL_HI_BIT   = 1;
    // Status register fields
    localparam int unsigned      FLAG_BIT     = 0;
    localparam int unsigned      DIS_BIT      = 1;
    localparam int unsigned      CLR_BIT      = 2;
    localparam int unsigned      POC_BIT      = 3;
    localparam int unsigned      LOWTH_BIT    = 4;
    // Synchronised pin indices
    localparam int unsigned      PIN_HI       = 0;
    localparam int unsigned      PIN_LO       = 1;
    localparam int unsigned      PIN_CE       = 2;
    // Carry period select codes, half periods in half-millisecond units
    localparam logic [1:0]       SEL_100MS    = 2'h0;
    localparam logic [1:0]       SEL_1MS      = 2'h1;
    localparam logic [1:0]       SEL_5MS      = 2'h2;
    localparam logic [1:0]       SEL_10MS     = 2'h3;
    localparam logic [7:0]       PER_100MS    = 8'h64;
    localparam logic [7:0]       PER_1MS      = 8'h01;
    localparam logic [7:0]       PER_5MS      = 8'h05;
    localparam logic [7:0]       PER_10MS     = 8'h0a;
    // Timing
    localparam int unsigned      CLK_PS       = 4000;
    localparam int unsigned      TICK_PS      = 500000000;
    localparam int unsigned      TICK_CYC     = TICK_PS / CLK_PS;
    localparam int unsigned      WAKE_MS      = 50;
    localparam int unsigned      TICKS_PER_MS = 2;
    localparam logic [7:0]       WAKE_TICKS   = 8'(WAKE_MS * TICKS_PER_MS);
    localparam int unsigned      TICK_W       = 17;
endpackage : por_pkg

// file: verif/por_vmon.sv
// Supply monitor model: the two comparators ahead of the clear logic.
// Assumes the bench sets the supply level in millivolts on the clock edge.
`timescale 1ns/10ps
module por_vmon #(
    parameter int unsigned HI_MV = 3500,
    parameter int unsigned LO_MV = 2200
) (
    input  wire logic [11:0] vdd_mv_i,
    output logic             hi_ok_o,
    output logic             lo_ok_o
);
    assign hi_ok_o = (vdd_mv_i > 12'(HI_MV));
    assign lo_ok_o = (vdd_mv_i > 12'(LO_MV));
endmodule : por_vmon

// file: verif/por_ctrl_tb.sv
// Bench for power-on clear sequencing, chip-enable restart and carry-seen flag.
// Assumes the supply monitor model and a tick shortened to T cycles.
`timescale 1ns/10ps
module por_ctrl_tb;
    localparam int T = 4;
    logic        mclk_i;
    logic        rst_n_i;
    logic [11:0] vdd_mv;
    logic        hi_ok;
    logic        lo_ok;
    logic        ce;
    logic        cstop;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        clr;
    logic        osc;
    logic        crst;
    logic        halt;
    logic        st;
    logic        spoc;
    logic        cp;
    int          fail_count = 0;
    int          num_checks = 0;
    int          nst = 0;
    int          cyc = 0;
    int          n;
    int          k;

    por_vmon i_vmon (.vdd_mv_i(vdd_mv), .hi_ok_o(hi_ok), .lo_ok_o(lo_ok));
    por_ctrl #(.TICK_CYC(T)) i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .vdd_hi_ok_i(hi_ok), .vdd_lo_ok_i(lo_ok),
        .ce_pin_i(ce), .clock_stop_i(cstop), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .supply_low_clear_o(clr), .osc_en_o(osc),
        .core_reset_o(crst), .core_halt_o(halt), .start_o(st), .start_poc_o(spoc),
        .carry_pulse_o(cp)
    );

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (st === 1'b1) nst <= nst + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask : chk

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [3:0] a, input logic [7:0] e, input string m);
        @(posedge mclk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 chk(rdata, e, m);
    endtask : rreg

    // Event 0 start pulse, 1 carry rise, 2 clear high; n is -1 if the bound ran out
    task automatic wait_ev(input int sel, input int lim);
        logic p;
        p = cp;
        for (n = 0; n < lim; n++) begin
            @(posedge mclk_i);
            #1;
            if ((sel == 0 && st === 1'b1) || (sel == 1 && cp === 1'b1 && p === 1'b0)
                || (sel == 2 && clr === 1'b1)) return;
            p = cp;
        end
        n = -1;
    endtask : wait_ev

    task automatic sup(input logic [11:0] mv);
        @(posedge mclk_i);
        vdd_mv <= mv;
    endtask : sup

    function automatic logic [7:0] stat(input logic f, input logic d, input logic p);
        stat = 8'h00;
        stat[por_pkg::FLAG_BIT] = f;
        stat[por_pkg::DIS_BIT] = d;
        stat[por_pkg::POC_BIT] = p;
    endfunction : stat

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        rst_n_i = 1'b0;
        vdd_mv = 12'hbb8;
        ce = 1'b0;
        cstop = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        // Supply held below normal level since power-up
        repeat (40) @(posedge mclk_i);
        #1 chk(8'(clr), 8'h01, "clear");
        chk(8'(crst), 8'h01, "core reset");
        chk(8'(halt), 8'h01, "halt in clear");
        chk(8'(osc), 8'h00, "osc");
        wreg(por_pkg::REG_CTRL, 8'h02);
        rreg(por_pkg::REG_CTRL, 8'h00, "ctrl in clear");
        chk(8'(nst), 8'h00, "no start");
        $display("test 1 done");
        // Supply and chip-enable rise on the same edge
        sup(12'he10);
        ce <= 1'b1;
        wait_ev(0, 110 * T + 40);
        chk(8'(n >= 99 * T && n <= 101 * T + 8), 8'h01, "start delay");
        chk(8'(spoc), 8'h01, "poc start");
        chk(8'(halt), 8'h00, "running");
        rreg(por_pkg::REG_STAT, stat(1'h0, 1'h1, 1'h1), "flag first");
        rreg(por_pkg::REG_STAT, stat(1'h0, 1'h0, 1'h1), "disable off");
        wait_ev(1, 1000);
        chk(8'(n >= 0), 8'h01, "carry rise");
        rreg(por_pkg::REG_STAT, stat(1'h1, 1'h0, 1'h1), "flag set");
        rreg(por_pkg::REG_STAT, stat(1'h0, 1'h0, 1'h1), "read clears");
        chk(8'(nst), 8'h01, "single start");
        // Period change as one write at the end of initial processing
        wreg(por_pkg::REG_CTRL, {6'h00, por_pkg::SEL_5MS});
        rreg(por_pkg::REG_CTRL, {6'h00, por_pkg::SEL_5MS}, "ctrl");
        rreg(4'hf, 8'h00, "unmapped");
        $display("test 2 done");
        // Chip-enable restart while running
        @(posedge mclk_i);
        ce <= 1'b0;
        repeat (8) @(posedge mclk_i);
        ce <= 1'b1;
        wait_ev(0, 400);
        chk(8'(n >= 0), 8'h01, "ce start");
        chk(8'(cp), 8'h01, "at carry rise");
        chk(8'(spoc), 8'h00, "ce cause");
        chk(8'(halt), 8'h00, "ce running");
        rreg(por_pkg::REG_STAT, stat(1'h1, 1'h0, 1'h0), "ce flag");
        $display("test 3 done");
        // Supply dip in normal run, chip-enable rising in the forced halt
        sup(12'hbb8);
        wait_ev(2, 10);
        chk(8'(n >= 0), 8'h01, "dip clear");
        // State register follows the clear one edge later
        @(posedge mclk_i);
        #1 chk(8'(crst), 8'h01, "dip reset");
        chk(8'(osc), 8'h00, "dip osc");
        wreg(por_pkg::REG_CTRL, 8'h03);
        rreg(por_pkg::REG_CTRL, 8'h00, "ctrl refused");
        sup(12'he10);
        ce <= 1'b0;
        repeat (20 * T) @(posedge mclk_i);
        ce <= 1'b1;
        k = nst;
        wait_ev(0, 110 * T + 40);
        chk(8'(n >= 0), 8'h01, "halt ce start");
        chk(8'(spoc), 8'h01, "halt ce poc");
        repeat (1000) @(posedge mclk_i);
        #1 chk(8'(nst - k), 8'h01, "halt ce once");
        rreg(por_pkg::REG_STAT, stat(1'h0, 1'h1, 1'h1), "poc flag");
        $display("test 4 done");
        // Clock stop: low threshold, then recovery only above normal
        sup(12'hbb8);
        cstop <= 1'b1;
        repeat (20) @(posedge mclk_i);
        #1 chk(8'(clr), 8'h00, "stop low th");
        sup(12'h7d0);
        wait_ev(2, 10);
        chk(8'(n >= 0), 8'h01, "stop clear");
        sup(12'hbb8);
        cstop <= 1'b0;
        repeat (20) @(posedge mclk_i);
        #1 chk(8'(clr), 8'h01, "needs normal");
        sup(12'he10);
        wait_ev(0, 110 * T + 40);
        chk(8'(n >= 0), 8'h01, "stop start");
        chk(8'(spoc), 8'h01, "stop recover");
        $display("test 5 done");
        // Wake by chip-enable with the supply still below normal
        sup(12'hbb8);
        cstop <= 1'b1;
        ce <= 1'b0;
        repeat (20) @(posedge mclk_i);
        ce <= 1'b1;
        @(posedge mclk_i);
        cstop <= 1'b0;
        wait_ev(2, 110 * T + 40);
        chk(8'(n >= 99 * T - 8), 8'h01, "wake threshold");
        $display("test 6 done");
        close_out();
    end
endmodule : por_ctrl_tb
